// ---- common/xirq_pkg.sv ----
// package: offsets, field positions, reset values and state type of the transceiver register bank
package xirq_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_STATUS  = 8'hd4;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'hd8;
	localparam logic [7:0] ADDR_FAST_CT = 8'hdc;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int ST_SPEED  = 9;
	localparam int ST_DUPLEX = 8;
	localparam int ST_PAUSE  = 7;
	localparam int FL_NEG    = 6;
	localparam int FL_FAR    = 5;
	localparam int FL_LINK   = 4;
	localparam int FL_ACK    = 3;
	localparam int FL_PDF    = 2;
	localparam int FL_PAGE   = 1;
	localparam int FL_RXERR  = 0;
	localparam int NUM_FLAGS = 7;

	// ****************************************
	// fast line control fields
	// ****************************************
	localparam int CT_CNT_OFF = 13;
	localparam int CT_NEGDONE = 12;
	localparam int CT_LOOP    = 9;
	localparam int CT_DCR     = 8;
	localparam int CT_NRZI    = 7;
	localparam int CT_ISO     = 5;
	localparam int CT_MODE_HI = 4;
	localparam int CT_MODE_LO = 2;
	localparam int CT_MLT     = 1;
	localparam int CT_SCR     = 0;

	// ****************************************
	// counts
	// ****************************************
	localparam int RX_ERR_LIMIT = 64;
	localparam int CNT_W        = 7;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [NUM_FLAGS-1:0] flags;
		logic [NUM_FLAGS-1:0] irqEnable;
		logic [CNT_W-1:0]     errCount;
		logic                 cntOff;
		logic                 loopOn;
		logic                 dcrOn;
		logic                 nrziOn;
		logic                 tx_isolate;
		logic                 mltBypass;
		logic                 scrBypass;
		logic [15:0]          rdData;
		logic                 irq;
	} xirq_state_t;

	localparam xirq_state_t RESET_STATE = '{
		flags:     7'h00,
		irqEnable: 7'h00,
		errCount:  7'h00,
		cntOff:    1'b0,
		loopOn:    1'b0,
		dcrOn:     1'b1,
		nrziOn:    1'b1,
		tx_isolate:     1'b0,
		mltBypass: 1'b0,
		scrBypass: 1'b0,
		rdData:    16'h0000,
		irq:       1'b0
	};

endpackage : xirq_pkg

// ---- rtl/xirq_regs.sv ----
// transceiver status, interrupt enable and fast line control register bank
//
// Local design decision: strobed register access.

module xirq_regs #(
	parameter int ERR_LIMIT = xirq_pkg::RX_ERR_LIMIT
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [15:0] regRdData,
	// resolved link state from the transceiver core
	input  wire logic        linkSpeed100,
	input  wire logic        linkFullDuplex,
	input  wire logic        pauseEnabled,
	input  wire logic        negotiationComplete,
	input  wire logic [2:0]  currentOperatingMode,
	// one-cycle events from the transceiver core
	input  wire logic        negotiationDoneEvt,
	input  wire logic        farFaultEvt,
	input  wire logic        linkDownEvt,
	input  wire logic        partnerCodewordEvt,
	input  wire logic        parallelFaultEvt,
	input  wire logic        pageReceivedEvt,
	input  wire logic        rxErrorEvt,
	// line controls
	output logic             farLoopbackOn,
	output logic             baselineRestoreOn,
	output logic             lineCodeConvertOn,
	output logic             txIsolate,
	output logic             threeLevelCodingBypass,
	output logic             scramblerBypass,
	// interrupt request
	output logic             xcvrIrq
);

	// ****************************************
	// state
	// ****************************************
	xirq_pkg::xirq_state_t s;
	xirq_pkg::xirq_state_t next_s;

	logic [xirq_pkg::NUM_FLAGS-1:0] evt;
	logic                           statusRead;

	// last count before the limit; the next error raises the overflow flag
	localparam logic [xirq_pkg::CNT_W-1:0] LAST_CNT = xirq_pkg::CNT_W'(ERR_LIMIT - 1);

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.rdData = 16'h0000;
		statusRead = regRdStb && (regAddr == xirq_pkg::ADDR_STATUS);
		evt = '0;
		evt[xirq_pkg::FL_NEG]  = negotiationDoneEvt;
		evt[xirq_pkg::FL_FAR]  = farFaultEvt;
		evt[xirq_pkg::FL_LINK] = linkDownEvt;
		evt[xirq_pkg::FL_ACK]  = partnerCodewordEvt;
		evt[xirq_pkg::FL_PDF]  = parallelFaultEvt;
		evt[xirq_pkg::FL_PAGE] = pageReceivedEvt;

		// error counter wraps to zero on the limit so a fresh 64 raise the flag again
		if (!s.cntOff && rxErrorEvt) begin
			if (s.errCount == xirq_pkg::CNT_W'(ERR_LIMIT - 1)) begin
				next_s.errCount = '0;
				evt[xirq_pkg::FL_RXERR] = 1'b1;
			end else begin
				next_s.errCount = s.errCount + 7'h01;
			end
		end

		// read data captured before the clear; a same-cycle event survives the clear
		if (regRdStb) begin
			case (regAddr)
				xirq_pkg::ADDR_STATUS: begin
					next_s.rdData[xirq_pkg::ST_SPEED]  = linkSpeed100;
					next_s.rdData[xirq_pkg::ST_DUPLEX] = linkFullDuplex;
					next_s.rdData[xirq_pkg::ST_PAUSE]  = pauseEnabled;
					next_s.rdData[xirq_pkg::NUM_FLAGS-1:0] = s.flags;
				end
				xirq_pkg::ADDR_IRQ_EN: begin
					next_s.rdData[xirq_pkg::NUM_FLAGS-1:0] = s.irqEnable;
				end
				xirq_pkg::ADDR_FAST_CT: begin
					next_s.rdData[xirq_pkg::CT_CNT_OFF] = s.cntOff;
					next_s.rdData[xirq_pkg::CT_NEGDONE] = negotiationComplete;
					next_s.rdData[xirq_pkg::CT_LOOP]    = s.loopOn;
					next_s.rdData[xirq_pkg::CT_DCR]     = s.dcrOn;
					next_s.rdData[xirq_pkg::CT_NRZI]    = s.nrziOn;
					next_s.rdData[xirq_pkg::CT_ISO]     = s.tx_isolate;
					next_s.rdData[xirq_pkg::CT_MODE_HI:xirq_pkg::CT_MODE_LO] =
						currentOperatingMode;
					next_s.rdData[xirq_pkg::CT_MLT]     = s.mltBypass;
					next_s.rdData[xirq_pkg::CT_SCR]     = s.scrBypass;
				end
				default: begin
					next_s.rdData = 16'h0000;
				end
			endcase
		end

		next_s.flags = (statusRead ? '0 : s.flags) | evt;

		if (regWrStb) begin
			case (regAddr)
				xirq_pkg::ADDR_IRQ_EN: begin
					next_s.irqEnable = regWrData[xirq_pkg::NUM_FLAGS-1:0];
				end
				xirq_pkg::ADDR_FAST_CT: begin
					next_s.cntOff    = regWrData[xirq_pkg::CT_CNT_OFF];
					next_s.loopOn    = regWrData[xirq_pkg::CT_LOOP];
					next_s.dcrOn     = regWrData[xirq_pkg::CT_DCR];
					next_s.nrziOn    = regWrData[xirq_pkg::CT_NRZI];
					next_s.tx_isolate     = regWrData[xirq_pkg::CT_ISO];
					next_s.mltBypass = regWrData[xirq_pkg::CT_MLT];
					next_s.scrBypass = regWrData[xirq_pkg::CT_SCR];
				end
				default: begin
					next_s.irqEnable = s.irqEnable;
				end
			endcase
		end

		// request follows the registered flags and enables in the same edge
		next_s.irq = |(next_s.flags & next_s.irqEnable);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= xirq_pkg::RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regRdData              = s.rdData;
	assign farLoopbackOn          = s.loopOn;
	assign baselineRestoreOn      = s.dcrOn;
	assign lineCodeConvertOn      = s.nrziOn;
	assign txIsolate              = s.tx_isolate;
	assign threeLevelCodingBypass = s.mltBypass;
	assign scramblerBypass        = s.scrBypass;
	assign xcvrIrq                = s.irq;

	// ****************************************
	// checks
	// ****************************************
	property p_speed_read;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr == xirq_pkg::ADDR_STATUS) |=>
			(regRdData[9] == $past(linkSpeed100) && regRdData[8] == $past(linkFullDuplex)
			&& regRdData[7] == $past(pauseEnabled));
	endproperty
	a_speed_read: assert property (p_speed_read) else $error("status link bits wrong");

	property p_event_latch;
		@(posedge ref_clk) disable iff (!rst_n)
		negotiationDoneEvt |=> s.flags[6];
	endproperty
	a_event_latch: assert property (p_event_latch) else $error("done flag not latched");

	property p_clear_on_read;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr == xirq_pkg::ADDR_STATUS && s.flags[5] && !farFaultEvt) |=>
			(regRdData[5] && !s.flags[5]);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("fault flag not cleared");

	property p_link_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		(s.flags[4] && !regRdStb) |=> s.flags[4];
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link flag dropped");

	property p_err_limit;
		@(posedge ref_clk) disable iff (!rst_n)
		(s.errCount == LAST_CNT && rxErrorEvt && !s.cntOff) |=> (s.flags[0] && s.errCount == 7'h00);
	endproperty
	a_err_limit: assert property (p_err_limit) else $error("error limit missed");

	property p_err_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		s.cntOff |=> $stable(s.errCount);
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("counter ran while stopped");

	property p_mode_read;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr == xirq_pkg::ADDR_FAST_CT) |=>
			(regRdData[4:2] == $past(currentOperatingMode)
			&& regRdData[12] == $past(negotiationComplete));
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

	property p_ctrl_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == xirq_pkg::ADDR_FAST_CT) |=>
			({farLoopbackOn, baselineRestoreOn, lineCodeConvertOn, txIsolate,
			threeLevelCodingBypass, scramblerBypass} ==
			{$past(regWrData[9]), $past(regWrData[8]), $past(regWrData[7]),
			$past(regWrData[5]), $past(regWrData[1]), $past(regWrData[0])});
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_irq;
		@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == xirq_pkg::ADDR_IRQ_EN && (regWrData[6:0] & s.flags) != 7'h00
		&& !regRdStb) |=> xcvrIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("request not raised");

	// ****************************************
	// further checks
	// ****************************************
	// read data stand for one cycle only, zero otherwise
	property p_rd_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		!regRdStb |=> (regRdData == 16'h0000);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

	property p_unmapped;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr != xirq_pkg::ADDR_STATUS && regAddr != xirq_pkg::ADDR_IRQ_EN
		&& regAddr != xirq_pkg::ADDR_FAST_CT) |=> (regRdData == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// no disable here: the values must stand while reset is held
	property p_reset_vals;
		@(posedge ref_clk)
		!rst_n |=> (!xcvrIrq && baselineRestoreOn && lineCodeConvertOn && !farLoopbackOn
		&& !txIsolate && !threeLevelCodingBypass && !scramblerBypass
		&& s.irqEnable == 7'h00 && s.flags == 7'h00);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_en_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == xirq_pkg::ADDR_IRQ_EN) |=>
			(s.irqEnable == $past(regWrData[6:0]));
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable write lost");

	property p_en_read;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr == xirq_pkg::ADDR_IRQ_EN) |=>
			(regRdData == {9'h000, $past(s.irqEnable)});
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable read wrong");

	// every source latches at the edge of its pulse
	property p_evt_latch;
		@(posedge ref_clk) disable iff (!rst_n)
		(evt != 7'h00) |=> ((s.flags & $past(evt)) == $past(evt));
	endproperty
	a_evt_latch: assert property (p_evt_latch) else $error("event not latched");

	property p_irq_level;
		@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> (xcvrIrq == |(s.flags & s.irqEnable));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("request level wrong");

	property p_irq_drop;
		@(posedge ref_clk) disable iff (!rst_n)
		(statusRead && evt == 7'h00 && !regWrStb) |=> !xcvrIrq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("request not dropped");

	property p_cnt_run;
		@(posedge ref_clk) disable iff (!rst_n)
		(!s.cntOff && rxErrorEvt && s.errCount != LAST_CNT) |=>
			(s.errCount == $past(s.errCount) + 7'h01);
	endproperty
	a_cnt_run: assert property (p_cnt_run) else $error("counter did not count");

	// below the limit the overflow flag stays low
	property p_rxerr_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		(!s.flags[0] && !(rxErrorEvt && !s.cntOff && s.errCount == LAST_CNT)) |=>
			!s.flags[0];
	endproperty
	a_rxerr_quiet: assert property (p_rxerr_quiet) else $error("overflow flag early");

	property p_rxerr_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(statusRead && s.flags[0] && !evt[0]) |=> (regRdData[0] && !s.flags[0]);
	endproperty
	a_rxerr_clear: assert property (p_rxerr_clear) else $error("overflow flag kept");

	// control outputs only move on a control write
	property p_ctrl_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		!(regWrStb && regAddr == xirq_pkg::ADDR_FAST_CT) |=>
			$stable({farLoopbackOn, baselineRestoreOn, lineCodeConvertOn, txIsolate,
			threeLevelCodingBypass, scramblerBypass});
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control output moved");

	property p_ctrl_read;
		@(posedge ref_clk) disable iff (!rst_n)
		(regRdStb && regAddr == xirq_pkg::ADDR_FAST_CT) |=>
			(regRdData[15:14] == 2'b00 && regRdData[11:10] == 2'b00 && regRdData[6] == 1'b0
			&& regRdData[13] == $past(s.cntOff) && regRdData[8] == $past(s.dcrOn)
			&& regRdData[7] == $past(s.nrziOn) && regRdData[1] == $past(s.mltBypass)
			&& regRdData[0] == $past(s.scrBypass));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_status_rsvd;
		@(posedge ref_clk) disable iff (!rst_n)
		statusRead |=> (regRdData[15:10] == 6'h00);
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("status upper bits set");

	// a status write must not touch the latched flags
	property p_status_ro;
		@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == xirq_pkg::ADDR_STATUS && evt == 7'h00) |=>
			(s.flags == $past(s.flags));
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status flags written");

endmodule : xirq_regs

// ---- tb/xirq_core_model.sv ----
// transceiver core model: resolved link levels and one-cycle event pulses
module xirq_core_model (
	// clock
	input  wire logic       ref_clk,
	// {speed, duplex, pause, negotiated, mode[2:0]} and events in flag order
	output logic      [6:0] lvl,
	output logic      [6:0] evt
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		lvl = 7'h00;
		evt = 7'h00;
	end

	task automatic set_lvl(input logic [6:0] v);
		@(posedge ref_clk);
		lvl <= v;
	endtask : set_lvl

	// single-cycle pulses, so each call counts exactly once
	task automatic fire(input logic [6:0] m);
		@(posedge ref_clk);
		evt <= m;
		@(posedge ref_clk);
		evt <= 7'h00;
		#1;
	endtask : fire
endmodule : xirq_core_model

// ---- tb/tb_top.sv ----
// testbench for the transceiver status, enable and fast line control registers
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ****
	// signals
	// ****
	localparam int LIM = 4;
	logic        ref_clk;
	logic        rst_n;
	logic [7:0]  regAddr;
	logic [15:0] regWrData;
	logic        regWrStb;
	logic        regRdStb;
	logic [15:0] regRdData;
	logic [6:0]  lvl;
	logic [6:0]  evt;
	logic [5:0]  outs;
	logic        xcvrIrq;
	int          bad_count;
	int          comparisons;

	xirq_core_model xirq_core_model_i (.ref_clk(ref_clk), .lvl(lvl), .evt(evt));

	xirq_regs #(.ERR_LIMIT(LIM)) xirq_regs_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.linkSpeed100(lvl[6]), .linkFullDuplex(lvl[5]), .pauseEnabled(lvl[4]),
		.negotiationComplete(lvl[3]), .currentOperatingMode(lvl[2:0]),
		.negotiationDoneEvt(evt[6]), .farFaultEvt(evt[5]), .linkDownEvt(evt[4]),
		.partnerCodewordEvt(evt[3]), .parallelFaultEvt(evt[2]), .pageReceivedEvt(evt[1]),
		.rxErrorEvt(evt[0]), .farLoopbackOn(outs[5]), .baselineRestoreOn(outs[4]),
		.lineCodeConvertOn(outs[3]), .txIsolate(outs[2]),
		.threeLevelCodingBypass(outs[1]), .scramblerBypass(outs[0]), .xcvrIrq(xcvrIrq));

	// ****
	// bus and compare tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrStb <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRdStb <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask : rdc

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		chk({10'h0, outs}, 16'h0018);
		rdc(xirq_pkg::ADDR_IRQ_EN, 16'h0000);
		rdc(xirq_pkg::ADDR_FAST_CT, 16'h0180);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_status();
		xirq_core_model_i.set_lvl(7'h50);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0280);
		xirq_core_model_i.set_lvl(7'h20);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0100);
		xirq_core_model_i.set_lvl(7'h00);
		for (int i = 1; i < 7; i++) begin
			xirq_core_model_i.fire(7'(1 << i));
			rdc(xirq_pkg::ADDR_STATUS, 16'(1 << i));
			rdc(xirq_pkg::ADDR_STATUS, 16'h0000);
		end
		$display("test status done");
	endtask : t_status

	task automatic t_rxerr();
		wr(xirq_pkg::ADDR_FAST_CT, 16'h2180);
		repeat (LIM) xirq_core_model_i.fire(7'h01);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0000);
		wr(xirq_pkg::ADDR_FAST_CT, 16'h0180);
		repeat (LIM - 1) xirq_core_model_i.fire(7'h01);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0000);
		xirq_core_model_i.fire(7'h01);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0001);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0000);
		$display("test rxerr done");
	endtask : t_rxerr

	task automatic t_irq();
		wr(xirq_pkg::ADDR_IRQ_EN, 16'hffff);
		rdc(xirq_pkg::ADDR_IRQ_EN, 16'h007f);
		wr(xirq_pkg::ADDR_IRQ_EN, 16'h0020);
		xirq_core_model_i.fire(7'h02);
		chk({15'h0, xcvrIrq}, 16'h0000);
		xirq_core_model_i.fire(7'h20);
		chk({15'h0, xcvrIrq}, 16'h0001);
		rdc(xirq_pkg::ADDR_STATUS, 16'h0022);
		chk({15'h0, xcvrIrq}, 16'h0000);
		wr(xirq_pkg::ADDR_IRQ_EN, 16'h0000);
		$display("test irq done");
	endtask : t_irq

	task automatic t_ctrl();
		xirq_core_model_i.set_lvl(7'h0e);
		wr(xirq_pkg::ADDR_FAST_CT, 16'hffff);
		rdc(xirq_pkg::ADDR_FAST_CT, 16'h33bb);
		chk({10'h0, outs}, 16'h003f);
		for (int m = 0; m < 8; m++) begin
			xirq_core_model_i.set_lvl(7'h08 | 7'(m));
			rdc(xirq_pkg::ADDR_FAST_CT, 16'h33a3 | 16'(m << 2));
		end
		wr(xirq_pkg::ADDR_FAST_CT, 16'h0000);
		chk({10'h0, outs}, 16'h0000);
		wr(8'hd0, 16'hffff);
		rdc(8'hd0, 16'h0000);
		rdc(xirq_pkg::ADDR_FAST_CT, 16'h101c);
		wr(xirq_pkg::ADDR_FAST_CT, 16'h0180);
		$display("test ctrl done");
	endtask : t_ctrl

	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// ****
	// clock, reset, sequence and watchdog
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		bad_count = 0;
		comparisons = 0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_status();
		t_rxerr();
		t_irq();
		t_ctrl();
		print_verdict();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
endmodule : tb_top
